/* hw/nrl_pkg.sv */
// nrl_pkg: shared constants of the network route and unit address lookup.
// assumes a 32-bit register port with byte addresses on aligned words.
package nrl_pkg;

  // table sizes and entry widths
  localparam int LOC_DEPTH     = 16;
  localparam int RLY_DEPTH     = 20;
  localparam int LOC_W         = 13;
  localparam int RLY_W         = 29;
  localparam int NET_W         = 7;
  localparam int UNIT_W        = 4;

  // local entry layout: valid, small link, bus unit number, network
  localparam int LOC_NET_LSB   = 0;
  localparam int LOC_UNIT_LSB  = 7;
  localparam int LOC_SMALL_BIT = 11;
  localparam int LOC_VALID_BIT = 12;

  // relay entry layout: valid, station name label, relay node, relay net, dest
  localparam int RLY_DEST_LSB  = 0;
  localparam int RLY_RNET_LSB  = 7;
  localparam int RLY_NODE_LSB  = 14;
  localparam int RLY_NAME_LSB  = 21;
  localparam int RLY_VALID_BIT = 28;

  // register byte offsets
  localparam logic [7:0] ADR_CTRL     = 8'h00;
  localparam logic [7:0] ADR_STATUS   = 8'h04;
  localparam logic [7:0] ADR_MASK     = 8'h08;
  localparam logic [7:0] ADR_LOC_SEL  = 8'h0C;
  localparam logic [7:0] ADR_LOC_DATA = 8'h10;
  localparam logic [7:0] ADR_RLY_SEL  = 8'h14;
  localparam logic [7:0] ADR_RLY_DATA = 8'h18;
  localparam logic [7:0] ADR_INFO     = 8'h1C;

  localparam int CTRL_RESTART_BIT = 0;
  localparam int ST_FAIL_BIT      = 0;
  localparam int ST_TERR_BIT      = 1;
  localparam int ST_DONE_BIT      = 2;
  localparam int ST_W             = 3;
  localparam logic [2:0] STATUS_RST = 3'h0;
  localparam logic [2:0] MASK_RST   = 3'h0;
  localparam int INFO_LOC_LSB     = 0;
  localparam int INFO_RLY_LSB     = 8;

  // unit addresses and value limits
  localparam logic [7:0] UA_CPU      = 8'h00;
  localparam logic [7:0] UA_APP      = 8'h01;
  localparam logic [7:0] UA_BUS_BASE = 8'h10;
  localparam logic [7:0] UA_RIO_BASE = 8'h90;
  localparam logic [7:0] UA_RIO_LAST = 8'hCF;
  localparam logic [7:0] UA_CONN     = 8'hFE;
  localparam logic [6:0] NET_NONE    = 7'h00;
  localparam logic [6:0] NODE_NONE   = 7'h00;
  localparam logic [6:0] NODE_MAX    = 7'h7E;
  localparam logic [6:0] SMALL_NODE_MAX = 7'h3E;

  typedef enum logic [2:0] {
    KIND_NONE = 3'h0,
    KIND_CPU  = 3'h1,
    KIND_BUS  = 3'h2,
    KIND_CONN = 3'h3,
    KIND_RIO  = 3'h4,
    KIND_APP  = 3'h5
  } nrl_kind_t;

endpackage

/* hw/nrl_table.sv */
// nrl_table: staged and active copies of one routing table.
// assumes the caller keeps wr_idx in range; commit copies stage to active.
`timescale 1ns/10ps
`default_nettype none
module nrl_table #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 13,
  parameter int IW    = $clog2(DEPTH)
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire logic                   wr_en,
  input  wire logic [IW-1:0]          wr_idx,
  input  wire logic [WIDTH-1:0]       wr_data,
  input  wire logic                   commit,
  input  wire logic                   rd_en,
  input  wire logic [IW-1:0]          rd_idx,
  output logic      [WIDTH-1:0]       rd_q,
  output logic      [DEPTH*WIDTH-1:0] act_flat
);

  logic [WIDTH-1:0] stage_r [DEPTH];
  logic [WIDTH-1:0] act_r   [DEPTH];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) stage_r[i] <= '0;
    end else if (wr_en) begin
      stage_r[wr_idx] <= wr_data;
    end
  end

  // the lookup only ever sees the active copy, so edits stay harmless until restart
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) act_r[i] <= '0;
    end else if (commit) begin
      for (int i = 0; i < DEPTH; i++) act_r[i] <= stage_r[i];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= '0;
    end else if (rd_en) begin
      rd_q <= (int'(rd_idx) < DEPTH) ? act_r[rd_idx] : '0;
    end
  end

  for (genvar g = 0; g < DEPTH; g++) begin : g_flat
    assign act_flat[g*WIDTH +: WIDTH] = act_r[g];
  end

endmodule
`default_nettype wire

/* hw/nrl_unit_dec.sv */
// nrl_unit_dec: decodes a destination unit address into a target kind.
// assumes is_pc tells whether the destination node is a computer node.
`timescale 1ns/10ps
`default_nettype none
module nrl_unit_dec (
  input  wire logic [7:0] ua,
  input  wire logic       is_pc,
  output nrl_pkg::nrl_kind_t kind,
  output logic      [3:0] unit,
  output logic      [1:0] master
);

  logic [7:0] rio_off;

  always_comb begin
    rio_off = ua - nrl_pkg::UA_RIO_BASE;
    kind    = nrl_pkg::KIND_NONE;
    unit    = 4'h0;
    master  = 2'h0;
    if (ua == nrl_pkg::UA_CONN) begin
      kind = nrl_pkg::KIND_CONN;
    end else if (is_pc) begin
      if (ua == nrl_pkg::UA_APP) begin
        kind = nrl_pkg::KIND_APP;
      end else if (ua == nrl_pkg::UA_BUS_BASE) begin
        kind = nrl_pkg::KIND_BUS;
      end
    end else if (ua == nrl_pkg::UA_CPU) begin
      kind = nrl_pkg::KIND_CPU;
    end else if (ua[7:4] == nrl_pkg::UA_BUS_BASE[7:4]) begin
      kind = nrl_pkg::KIND_BUS;
      unit = ua[3:0];
    end else if (ua >= nrl_pkg::UA_RIO_BASE && ua <= nrl_pkg::UA_RIO_LAST) begin
      // slaves of all four groups 0..3 have addresses 90..CF here; bits 5:4 of the offset pick the group
      kind   = nrl_pkg::KIND_RIO;
      unit   = ua[3:0];
      master = rio_off[5:4];
    end
  end

endmodule
`default_nettype wire

/* hw/nrl_router.sv */
// nrl_router: route lookup for command messages with software-set tables.
// assumes one synchronous clock; requests are one-cycle pulses, never stalled.
//
// Chosen here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module nrl_router (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic             irq,
  input  wire logic        req_valid,
  input  wire logic        req_by_name,
  input  wire logic [6:0]  req_name,
  input  wire logic [6:0]  req_dst_net,
  input  wire logic [6:0]  req_dst_node,
  input  wire logic [7:0]  req_unit_addr,
  input  wire logic        req_dst_pc,
  output logic             rsp_valid,
  output logic             rsp_ok,
  output logic      [2:0]  rsp_kind,
  output logic             rsp_local,
  output logic      [3:0]  rsp_out_unit,
  output logic      [6:0]  rsp_next_net,
  output logic      [6:0]  rsp_next_node,
  output logic      [3:0]  rsp_dst_unit,
  output logic      [1:0]  rsp_master
);

  localparam int LD  = nrl_pkg::LOC_DEPTH;
  localparam int RD  = nrl_pkg::RLY_DEPTH;
  localparam int LW  = nrl_pkg::LOC_W;
  localparam int RW  = nrl_pkg::RLY_W;
  localparam int LIW = $clog2(LD);
  localparam int RIW = $clog2(RD);

  logic [2:0]       status_r;
  logic [2:0]       mask_r;
  logic [LIW-1:0]   loc_sel_r;
  logic [RIW-1:0]   rly_sel_r;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  logic             rd_loc_r;
  logic             rd_rly_r;
  logic [LW-1:0]    loc_q;
  logic [RW-1:0]    rly_q;
  logic [LD*LW-1:0] loc_act;
  logic [RD*RW-1:0] rly_act;

  logic wr_ctrl;
  logic wr_loc;
  logic wr_rly;
  logic commit;
  logic loc_bad;
  logic rly_bad;
  logic [2:0] ev;
  logic [2:0] clr;

  // register port decode
  assign wr_ctrl = reg_wr && (reg_addr == nrl_pkg::ADR_CTRL);
  assign wr_loc  = reg_wr && (reg_addr == nrl_pkg::ADR_LOC_DATA);
  assign wr_rly  = reg_wr && (reg_addr == nrl_pkg::ADR_RLY_DATA);
  assign commit  = wr_ctrl && reg_wdata[nrl_pkg::CTRL_RESTART_BIT];

  // a valid local entry needs a nonzero net; the 4-bit unit field cannot leave 0..15
  assign loc_bad = reg_wdata[nrl_pkg::LOC_VALID_BIT] &&
                   (reg_wdata[nrl_pkg::LOC_NET_LSB +: 7] == nrl_pkg::NET_NONE);

  // relay node range is the wide one here; the small-link bound needs the local table
  assign rly_bad = (int'(rly_sel_r) >= RD) ||
                   (reg_wdata[nrl_pkg::RLY_VALID_BIT] &&
                    ((reg_wdata[nrl_pkg::RLY_DEST_LSB +: 7] == nrl_pkg::NET_NONE) ||
                     (reg_wdata[nrl_pkg::RLY_RNET_LSB +: 7] == nrl_pkg::NET_NONE) ||
                     (reg_wdata[nrl_pkg::RLY_NODE_LSB +: 7] == nrl_pkg::NODE_NONE) ||
                     (reg_wdata[nrl_pkg::RLY_NODE_LSB +: 7] > nrl_pkg::NODE_MAX)));

  nrl_table #(.DEPTH(LD), .WIDTH(LW)) u_loc (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .wr_en    (wr_loc && !loc_bad),
    .wr_idx   (loc_sel_r),
    .wr_data  (reg_wdata[LW-1:0]),
    .commit   (commit),
    .rd_en    (reg_rd && (reg_addr == nrl_pkg::ADR_LOC_DATA)),
    .rd_idx   (loc_sel_r),
    .rd_q     (loc_q),
    .act_flat (loc_act)
  );

  nrl_table #(.DEPTH(RD), .WIDTH(RW)) u_rly (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .wr_en    (wr_rly && !rly_bad),
    .wr_idx   (rly_sel_r),
    .wr_data  (reg_wdata[RW-1:0]),
    .commit   (commit),
    .rd_en    (reg_rd && (reg_addr == nrl_pkg::ADR_RLY_DATA)),
    .rd_idx   (rly_sel_r),
    .rd_q     (rly_q),
    .act_flat (rly_act)
  );

  // lookup over the active tables
  logic       name_hit;
  logic [6:0] name_net;
  logic [6:0] name_node;
  logic [6:0] dnet;
  logic [6:0] dnode;
  logic       loc_hit;
  logic [3:0] loc_unit;
  logic       rly_hit;
  logic [6:0] rly_net;
  logic [6:0] rly_node;
  logic       via_hit;
  logic [3:0] via_unit;
  logic       via_small;
  logic [4:0] loc_cnt;
  logic [4:0] rly_cnt;

  always_comb begin
    name_hit  = 1'b0;
    name_net  = nrl_pkg::NET_NONE;
    name_node = nrl_pkg::NODE_NONE;
    rly_hit   = 1'b0;
    rly_net   = nrl_pkg::NET_NONE;
    rly_node  = nrl_pkg::NODE_NONE;
    rly_cnt   = 5'h00;
    for (int j = 0; j < RD; j++) begin
      if (rly_act[j*RW + nrl_pkg::RLY_VALID_BIT]) begin
        rly_cnt = rly_cnt + 5'h01;
        // a label of zero means the node has no station name
        if (!name_hit && rly_act[j*RW + nrl_pkg::RLY_NAME_LSB +: 7] != 7'h00 &&
            rly_act[j*RW + nrl_pkg::RLY_NAME_LSB +: 7] == req_name) begin
          name_hit  = 1'b1;
          name_net  = rly_act[j*RW + nrl_pkg::RLY_DEST_LSB +: 7];
          name_node = rly_act[j*RW + nrl_pkg::RLY_NODE_LSB +: 7];
        end
      end
    end
    dnet  = req_by_name ? name_net  : req_dst_net;
    dnode = req_by_name ? name_node : req_dst_node;
    for (int j = 0; j < RD; j++) begin
      if (!rly_hit && rly_act[j*RW + nrl_pkg::RLY_VALID_BIT] &&
          rly_act[j*RW + nrl_pkg::RLY_DEST_LSB +: 7] == dnet) begin
        rly_hit  = 1'b1;
        rly_net  = rly_act[j*RW + nrl_pkg::RLY_RNET_LSB +: 7];
        rly_node = rly_act[j*RW + nrl_pkg::RLY_NODE_LSB +: 7];
      end
    end
    loc_hit   = 1'b0;
    loc_unit  = 4'h0;
    via_hit   = 1'b0;
    via_unit  = 4'h0;
    via_small = 1'b0;
    loc_cnt   = 5'h00;
    for (int i = 0; i < LD; i++) begin
      if (loc_act[i*LW + nrl_pkg::LOC_VALID_BIT]) begin
        loc_cnt = loc_cnt + 5'h01;
        if (!loc_hit && loc_act[i*LW + nrl_pkg::LOC_NET_LSB +: 7] == dnet) begin
          loc_hit  = 1'b1;
          loc_unit = loc_act[i*LW + nrl_pkg::LOC_UNIT_LSB +: 4];
        end
        if (!via_hit && loc_act[i*LW + nrl_pkg::LOC_NET_LSB +: 7] == rly_net) begin
          via_hit   = 1'b1;
          via_unit  = loc_act[i*LW + nrl_pkg::LOC_UNIT_LSB +: 4];
          via_small = loc_act[i*LW + nrl_pkg::LOC_SMALL_BIT];
        end
      end
    end
  end

  nrl_pkg::nrl_kind_t dec_kind;
  logic [3:0]         dec_unit;
  logic [1:0]         dec_master;

  nrl_unit_dec u_dec (
    .ua     (req_unit_addr),
    .is_pc  (req_dst_pc),
    .kind   (dec_kind),
    .unit   (dec_unit),
    .master (dec_master)
  );

  logic       ok;
  logic       conflict;
  logic       is_local;
  logic [3:0] out_unit;
  logic [6:0] next_net;
  logic [6:0] next_node;

  // priority: own node, attached network, relay path; anything else fails
  always_comb begin
    ok        = 1'b0;
    conflict  = 1'b0;
    is_local  = 1'b0;
    out_unit  = 4'h0;
    next_net  = dnet;
    next_node = dnode;
    if (req_by_name && !name_hit) begin
      ok = 1'b0;
    end else if (dnet == nrl_pkg::NET_NONE) begin
      // own node, including remote io slaves that carry no net address
      is_local = 1'b1;
      ok       = 1'b1;
    end else if (loc_hit) begin
      ok       = 1'b1;
      out_unit = loc_unit;
    end else if (rly_hit) begin
      if (via_hit && !(via_small && rly_node > nrl_pkg::SMALL_NODE_MAX)) begin
        ok        = 1'b1;
        out_unit  = via_unit;
        next_net  = rly_net;
        next_node = rly_node;
      end else begin
        conflict = 1'b1;
      end
    end
    if (dec_kind == nrl_pkg::KIND_NONE) begin
      ok = 1'b0;
    end
  end

  // responses one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid     <= 1'b0;
      rsp_ok        <= 1'b0;
      rsp_kind      <= 3'h0;
      rsp_local     <= 1'b0;
      rsp_out_unit  <= 4'h0;
      rsp_next_net  <= 7'h00;
      rsp_next_node <= 7'h00;
      rsp_dst_unit  <= 4'h0;
      rsp_master    <= 2'h0;
    end else begin
      rsp_valid <= req_valid;
      if (req_valid) begin
        rsp_ok        <= ok;
        rsp_kind      <= dec_kind;
        rsp_local     <= is_local;
        rsp_out_unit  <= out_unit;
        rsp_next_net  <= next_net;
        rsp_next_node <= next_node;
        rsp_dst_unit  <= dec_unit;
        rsp_master    <= dec_master;
      end
    end
  end

  // sticky events; a new event beats a write-one-to-clear in the same cycle
  always_comb begin
    ev = 3'h0;
    ev[nrl_pkg::ST_FAIL_BIT] = req_valid && !ok;
    ev[nrl_pkg::ST_TERR_BIT] = (req_valid && conflict) || (wr_loc && loc_bad) ||
                               (wr_rly && rly_bad);
    ev[nrl_pkg::ST_DONE_BIT] = commit;
    clr = (reg_wr && reg_addr == nrl_pkg::ADR_STATUS) ? reg_wdata[2:0] : 3'h0;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= nrl_pkg::STATUS_RST;
    end else begin
      status_r <= (status_r & ~clr) | ev;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_r    <= nrl_pkg::MASK_RST;
      loc_sel_r <= '0;
      rly_sel_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == nrl_pkg::ADR_MASK) mask_r <= reg_wdata[2:0];
      if (reg_addr == nrl_pkg::ADR_LOC_SEL) loc_sel_r <= reg_wdata[LIW-1:0];
      if (reg_addr == nrl_pkg::ADR_RLY_SEL) rly_sel_r <= reg_wdata[RIW-1:0];
    end
  end

  assign irq = |(status_r & mask_r);

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (reg_addr)
      nrl_pkg::ADR_STATUS:  rdata_nxt[2:0] = status_r;
      nrl_pkg::ADR_MASK:    rdata_nxt[2:0] = mask_r;
      nrl_pkg::ADR_LOC_SEL: rdata_nxt[LIW-1:0] = loc_sel_r;
      nrl_pkg::ADR_RLY_SEL: rdata_nxt[RIW-1:0] = rly_sel_r;
      nrl_pkg::ADR_INFO: begin
        rdata_nxt[nrl_pkg::INFO_LOC_LSB +: 5] = loc_cnt;
        rdata_nxt[nrl_pkg::INFO_RLY_LSB +: 5] = rly_cnt;
      end
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // read data exist only in the cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r  <= 32'h0000_0000;
      rd_loc_r <= 1'b0;
      rd_rly_r <= 1'b0;
    end else begin
      rdata_r  <= reg_rd ? rdata_nxt : 32'h0000_0000;
      rd_loc_r <= reg_rd && (reg_addr == nrl_pkg::ADR_LOC_DATA);
      rd_rly_r <= reg_rd && (reg_addr == nrl_pkg::ADR_RLY_DATA);
    end
  end

  assign reg_rdata = rd_loc_r ? {{(32-LW){1'b0}}, loc_q} :
                     rd_rly_r ? {{(32-RW){1'b0}}, rly_q} : rdata_r;

  // checks
  sequence s_restart;
    wr_ctrl && reg_wdata[nrl_pkg::CTRL_RESTART_BIT];
  endsequence

  sequence s_fail_unmasked;
    req_valid && !ok && mask_r[nrl_pkg::ST_FAIL_BIT];
  endsequence

  a_restart_done: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_restart |=> status_r[nrl_pkg::ST_DONE_BIT])
    else $error("restart did not raise done");

  a_tables_hold: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (loc_cnt != $past(loc_cnt) || rly_cnt != $past(rly_cnt)) |-> $past(commit))
    else $error("active table changed without restart");

  a_fail_irq: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    s_fail_unmasked |=> irq && rsp_valid && !rsp_ok)
    else $error("routing failure not reported");

  a_rsp_timing: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    req_valid |=> rsp_valid ##1 (!rsp_valid || $past(req_valid)))
    else $error("response not one cycle after request");

  a_bad_local: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (wr_loc && loc_bad) |=> status_r[nrl_pkg::ST_TERR_BIT])
    else $error("bad local entry not flagged");

  a_cpu_unit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (req_valid && !req_dst_pc && req_unit_addr == nrl_pkg::UA_CPU) |=>
    rsp_kind == nrl_pkg::KIND_CPU)
    else $error("unit address 00 not routed to cpu");

  a_bus_unit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (req_valid && !req_dst_pc && req_unit_addr[7:4] == 4'h1) |=>
    rsp_kind == nrl_pkg::KIND_BUS && rsp_dst_unit == $past(req_unit_addr[3:0]))
    else $error("bus unit address decoded wrong");

  a_conn_unit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (req_valid && req_unit_addr == nrl_pkg::UA_CONN) |=> rsp_kind == nrl_pkg::KIND_CONN)
    else $error("FE not routed to connecting unit");

  a_rio_slave: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (req_valid && !req_dst_pc && req_unit_addr == 8'hB5) |=>
    rsp_kind == nrl_pkg::KIND_RIO && rsp_master == 2'h2 && rsp_dst_unit == 4'h5)
    else $error("remote io slave address decoded wrong");

  a_host_app: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (req_valid && req_dst_pc && req_unit_addr == nrl_pkg::UA_APP) |=>
    rsp_kind == nrl_pkg::KIND_APP)
    else $error("01 at computer node not routed to application");

  a_relay_path: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (req_valid && ok && !loc_hit && !is_local) |=>
    rsp_next_net == $past(rly_net) && rsp_next_node == $past(rly_node))
    else $error("relay destination not sent via relay node");

endmodule
`default_nettype wire

/* verif/nrl_far_model.sv */
// nrl_far_model: stands in for the communication units that ask for routes.
// assumes the router takes a request on the rising edge where req_valid is high.
`timescale 1ns/10ps
`default_nettype none
module nrl_far_model (
  input  wire logic       sys_clk,
  output logic            req_valid,
  output logic            req_by_name,
  output logic      [6:0] req_name,
  output logic      [6:0] req_dst_net,
  output logic      [6:0] req_dst_node,
  output logic      [7:0] req_unit_addr,
  output logic            req_dst_pc
);
  initial begin
    req_valid     = 1'h0;
    req_by_name   = 1'h0;
    req_name      = 7'h00;
    req_dst_net   = 7'h00;
    req_dst_node  = 7'h00;
    req_unit_addr = 8'h00;
    req_dst_pc    = 1'h0;
  end

  // one request; released fields go inverted so a stale value is never reused
  task automatic send(input logic bn, input logic [6:0] nm, input logic [6:0] net,
                      input logic [6:0] nd, input logic [7:0] ua, input logic pc);
    @(posedge sys_clk);
    req_valid     <= 1'h1;
    req_by_name   <= bn;
    req_name      <= nm;
    req_dst_net   <= net;
    req_dst_node  <= nd;
    req_unit_addr <= ua;
    req_dst_pc    <= pc;
    @(posedge sys_clk);
    req_valid     <= 1'h0;
    req_by_name   <= ~bn;
    req_name      <= ~nm;
    req_dst_net   <= ~net;
    req_dst_node  <= ~nd;
    req_unit_addr <= ~ua;
    req_dst_pc    <= ~pc;
  endtask
endmodule
`default_nettype wire

/* verif/nrl_router_test.sv */
// nrl_router_test: register and lookup scenarios for the route lookup block.
// assumes the far-side model drives the lookup port; the bench owns the registers.
`timescale 1ns/10ps
`default_nettype none
module nrl_router_test;
  logic        sys_clk, rst_n, reg_wr, reg_rd, irq, req_valid, req_by_name, req_dst_pc;
  logic        rsp_valid, rsp_ok, rsp_local;
  logic [7:0]  reg_addr, req_unit_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [6:0]  req_name, req_dst_net, req_dst_node, rsp_next_net, rsp_next_node;
  logic [3:0]  rsp_out_unit, rsp_dst_unit;
  logic [2:0]  rsp_kind;
  logic [1:0]  rsp_master;
  int          err_count, num_checks;
  localparam logic [28:0] M_ALL = 29'h1FFF_FFFF;
  localparam logic [28:0] M_NOU = 29'h1FFF_FFC0;
  localparam logic [28:0] M_OK  = 29'h1000_0000;
  localparam logic [28:0] M_OKK = 29'h1E00_0000;

  nrl_router dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq(irq), .req_valid(req_valid), .req_by_name(req_by_name), .req_name(req_name),
    .req_dst_net(req_dst_net), .req_dst_node(req_dst_node), .req_unit_addr(req_unit_addr),
    .req_dst_pc(req_dst_pc), .rsp_valid(rsp_valid), .rsp_ok(rsp_ok), .rsp_kind(rsp_kind),
    .rsp_local(rsp_local), .rsp_out_unit(rsp_out_unit), .rsp_next_net(rsp_next_net),
    .rsp_next_node(rsp_next_node), .rsp_dst_unit(rsp_dst_unit), .rsp_master(rsp_master));
  nrl_far_model u_far (.sys_clk(sys_clk), .req_valid(req_valid), .req_by_name(req_by_name),
    .req_name(req_name), .req_dst_net(req_dst_net), .req_dst_node(req_dst_node),
    .req_unit_addr(req_unit_addr), .req_dst_pc(req_dst_pc));

  always #5 sys_clk = ~sys_clk;

  task automatic results;
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    #1 chk("reg_rdata", reg_rdata, e);
  endtask

  task automatic wloc(input logic [31:0] idx, input logic [31:0] d);
    wr(nrl_pkg::ADR_LOC_SEL, idx);
    wr(nrl_pkg::ADR_LOC_DATA, d);
  endtask

  task automatic wrly(input logic [31:0] idx, input logic [31:0] d);
    wr(nrl_pkg::ADR_RLY_SEL, idx);
    wr(nrl_pkg::ADR_RLY_DATA, d);
  endtask

  // expected route as {ok, kind, local, out unit, next net, next node, unit, master}
  task automatic look(input logic bn, input logic [6:0] net, input logic [6:0] nd,
                      input logic [7:0] ua, input logic pc, input logic [28:0] e,
                      input logic [28:0] msk);
    u_far.send(bn, 7'h09, net, nd, ua, pc);
    #1 chk("rsp_valid", {31'h0, rsp_valid}, 32'h1);
    chk("route", {3'h0, msk & {rsp_ok, rsp_kind, rsp_local, rsp_out_unit, rsp_next_net,
        rsp_next_node, rsp_dst_unit, rsp_master}}, {3'h0, msk & e});
  endtask

  task automatic irq_is(input logic e);
    #1 chk("irq", {31'h0, irq}, {31'h0, e});
  endtask

  initial begin
    #100000;
    err_count++;
    results();
  end

  initial begin
    sys_clk = 1'h0;
    rst_n = 1'h0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'h1;
    rd(nrl_pkg::ADR_STATUS, 32'h0);
    rd(nrl_pkg::ADR_MASK, 32'h0);
    rd(8'h20, 32'h0);
    // every network gets its own address across the system
    wloc(32'h0, 32'h0000_1082);
    wloc(32'hF, 32'h0000_1784);
    wloc(32'h1, 32'h0000_1A83);
    wloc(32'h2, 32'h0000_1000);
    rd(nrl_pkg::ADR_INFO, 32'h0);
    wr(nrl_pkg::ADR_CTRL, 32'h1);
    rd(nrl_pkg::ADR_STATUS, 32'h6);
    rd(nrl_pkg::ADR_LOC_DATA, 32'h0);
    wr(nrl_pkg::ADR_LOC_SEL, 32'hF);
    rd(nrl_pkg::ADR_LOC_DATA, 32'h0000_1784);
    rd(nrl_pkg::ADR_INFO, 32'h3);
    rd(nrl_pkg::ADR_CTRL, 32'h0);
    wr(nrl_pkg::ADR_STATUS, 32'h7);
    rd(nrl_pkg::ADR_STATUS, 32'h0);
    look(1'h0, 7'h00, 7'h00, 8'h00, 1'h0,
         {1'h1, 3'h1, 1'h1, 24'h0}, 29'h1F00_0000);
    @(posedge sys_clk);
    #1 chk("rsp_valid", {31'h0, rsp_valid}, 32'h0);
    look(1'h0, 7'h02, 7'h04, 8'h13, 1'h0,
         {1'h1, 3'h2, 1'h0, 4'h1, 7'h02, 7'h04, 4'h3, 2'h0}, M_ALL);
    look(1'h0, 7'h00, 7'h00, 8'hCF, 1'h0,
         {1'h1, 3'h4, 1'h1, 18'h0, 4'hF, 2'h3}, 29'h1F00_003F);
    look(1'h0, 7'h02, 7'h04, 8'hFE, 1'h0,
         {1'h1, 3'h3, 1'h0, 4'h1, 7'h02, 7'h04, 6'h0}, M_NOU);
    look(1'h0, 7'h02, 7'h04, 8'h01, 1'h1,
         {1'h1, 3'h5, 1'h0, 4'h1, 7'h02, 7'h04, 6'h0}, M_NOU);
    look(1'h0, 7'h02, 7'h04, 8'h10, 1'h1,
         {1'h1, 3'h2, 1'h0, 4'h1, 7'h02, 7'h04, 4'h0, 2'h0}, 29'h1FFF_FFFC);
    look(1'h0, 7'h02, 7'h04, 8'hFE, 1'h1,
         {1'h1, 3'h3, 1'h0, 4'h1, 7'h02, 7'h04, 6'h0}, M_NOU);
    look(1'h0, 7'h02, 7'h04, 8'h50, 1'h0, 29'h0, M_OKK);
    look(1'h0, 7'h05, 7'h09, 8'h10, 1'h0, 29'h0, M_OK);
    rd(nrl_pkg::ADR_STATUS, 32'h1);
    wr(nrl_pkg::ADR_MASK, 32'h1);
    irq_is(1'h1);
    // a failure while its mask bit is set keeps the interrupt up
    look(1'h0, 7'h02, 7'h04, 8'h50, 1'h0, 29'h0, M_OKK);
    irq_is(1'h1);
    wr(nrl_pkg::ADR_MASK, 32'h0);
    irq_is(1'h0);
    wr(nrl_pkg::ADR_STATUS, 32'h7);
    wrly(32'h00, 32'h1121_C105);
    wrly(32'h01, 32'h1011_8186);
    wrly(32'h13, 32'h101F_8207);
    wrly(32'h02, 32'h101F_C105);
    wrly(32'h14, 32'h1121_C105);
    wr(nrl_pkg::ADR_CTRL, 32'h1);
    rd(nrl_pkg::ADR_STATUS, 32'h6);
    rd(nrl_pkg::ADR_INFO, 32'h0000_0303);
    rd(nrl_pkg::ADR_RLY_DATA, 32'h0);
    wr(nrl_pkg::ADR_RLY_SEL, 32'h13);
    rd(nrl_pkg::ADR_RLY_DATA, 32'h101F_8207);
    wr(nrl_pkg::ADR_STATUS, 32'h7);
    look(1'h0, 7'h05, 7'h09, 8'h10, 1'h0,
         {1'h1, 3'h2, 1'h0, 4'h1, 7'h02, 7'h07, 4'h0, 2'h0}, M_ALL);
    look(1'h1, 7'h00, 7'h00, 8'hB7, 1'h0,
         {1'h1, 3'h4, 1'h0, 4'h1, 7'h02, 7'h07, 4'h7, 2'h2}, M_ALL);
    look(1'h0, 7'h07, 7'h03, 8'h00, 1'h0,
         {1'h1, 3'h1, 1'h0, 4'hF, 7'h04, 7'h7E, 6'h0}, M_NOU);
    look(1'h0, 7'h06, 7'h03, 8'h10, 1'h0, 29'h0, M_OK);
    rd(nrl_pkg::ADR_STATUS, 32'h3);
    wr(nrl_pkg::ADR_MASK, 32'h2);
    irq_is(1'h1);
    wr(nrl_pkg::ADR_STATUS, 32'h2);
    irq_is(1'h0);
    rd(nrl_pkg::ADR_STATUS, 32'h1);
    results();
  end
endmodule
`default_nettype wire
